//--- hw/sarcc_clock_div.sv
// successive-approximation clock tick generator
// assumes divider code changes only while idle; a change mid-conversion just re-times ticks
`timescale 1ns/1ps
`default_nettype none
module sarcc_clock_div
    import sarcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [2:0] divCode,
    output logic            sarTick
);
    logic [DIV_CNT_WIDTH-1:0] cntReg;
    logic [DIV_CNT_WIDTH-1:0] limit;

    // ------------------------------------------------------------
    // divide factor decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (divCode)
            3'h0:    limit = 4'h0;
            3'h1:    limit = 4'h1;
            3'h2:    limit = 4'h3;
            3'h3:    limit = 4'h7;
            default: limit = 4'hF;
        endcase
    end

    // counter restarts when idle so the first tick is a full period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cntReg  <= '0;
            sarTick <= 1'b0;
        end else if (!run) begin
            cntReg  <= '0;
            sarTick <= 1'b0;
        end else if (cntReg >= limit) begin
            cntReg  <= '0;
            sarTick <= 1'b1;
        end else begin
            cntReg  <= cntReg + 4'h1;
            sarTick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- hw/sarcc_top.sv
// converter control: enable, start selection, tracking, busy, done flag, result
// assumes timer overflows and software write are one-cycle pulses on clk;
// the start pin and standby input are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module sarcc_top
    import sarcc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          convEnable,
    input  wire logic                          refBiasEnable,
    input  wire logic                          trackMode,
    input  wire logic                          startModeHi,
    input  wire logic                          startModeLo,
    input  wire logic                          leftJustify,
    input  wire logic [2:0]                    convClockDivider,
    input  wire logic [sarcc_pkg::CHAN_WIDTH-1:0] muxChannelSelect,
    input  wire logic [sarcc_pkg::PAIR_COUNT-1:0] muxPairConfig,
    input  wire logic                          pairConfigWrite,
    input  wire logic                          busyWrite,
    input  wire logic                          timer3Overflow,
    input  wire logic                          timer2Overflow,
    input  wire logic                          extConvStart,
    input  wire logic                          chipStandby,
    input  wire logic                          doneFlagClear,
    input  wire logic                          doneIrqEnable,
    input  wire logic [sarcc_pkg::RESULT_WIDTH-1:0] sarData,
    output logic                               convBusy,
    output logic                               convDoneFlag,
    output logic                               convIrq,
    output logic [7:0]                         resultHigh,
    output logic [7:0]                         resultLow,
    output logic                               analogPowerUp,
    output logic                               trackActive,
    output logic                               sarConvert,
    output logic [sarcc_pkg::CHAN_WIDTH-1:0]   muxChannel,
    output logic                               muxDifferential,
    output logic                               muxTempSensor,
    output logic [sarcc_pkg::PAIR_COUNT-1:0]   pairConfig
);
    import sarcc_pkg::*;

    typedef enum logic [1:0] {IDLE, TRACK, CONVERT} sarcc_state_t;

    sarcc_state_t state_reg;
    logic [4:0]   count_reg;
    logic         pinSync1_reg;
    logic         pinSync2_reg;
    logic         pinLast_reg;
    logic         stbySync1_reg;
    logic         stbySync2_reg;
    logic [1:0]   startMode;
    logic         startEvent;
    logic         pinRise;
    logic         sarTick;
    logic         active;
    logic         finish;
    logic         diffSel;
    logic         idleStart;

    // ------------------------------------------------------------
    // synchronisers and start selection
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinSync1_reg  <= 1'b1;
            pinSync2_reg  <= 1'b1;
            pinLast_reg   <= 1'b1;
            stbySync1_reg <= 1'b0;
            stbySync2_reg <= 1'b0;
        end else begin
            pinSync1_reg  <= extConvStart;
            pinSync2_reg  <= pinSync1_reg;
            pinLast_reg   <= pinSync2_reg;
            stbySync1_reg <= chipStandby;
            stbySync2_reg <= stbySync1_reg;
        end
    end

    assign startMode = {startModeHi, startModeLo};
    assign pinRise   = pinSync2_reg & ~pinLast_reg;
    // bias is software's job; without it no conversion is started
    assign active    = convEnable & refBiasEnable;
    // accepted start, so tracking stops on the same edge busy rises
    assign idleStart = (state_reg == IDLE) && startEvent;

    always_comb begin
        unique case (startMode)
            START_SOFTWARE: startEvent = busyWrite;
            START_TIMER3:   startEvent = timer3Overflow;
            START_EXTPIN:   startEvent = pinRise;
            START_TIMER2:   startEvent = timer2Overflow;
        endcase
    end

    sarcc_clock_div u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (state_reg != IDLE),
        .divCode (convClockDivider),
        .sarTick (sarTick)
    );

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    assign finish = (state_reg == CONVERT) && sarTick && (count_reg == CONV_SAR_CLOCKS - 5'h01);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= IDLE;
            count_reg <= '0;
        end else if (!active) begin
            state_reg <= IDLE;
            count_reg <= '0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    // new starts only taken here, so busy ignores them
                    if (startEvent) begin
                        state_reg <= (trackMode && startMode != START_EXTPIN) ? TRACK : CONVERT;
                        count_reg <= '0;
                    end
                end
                TRACK: begin
                    if (sarTick) begin
                        if (count_reg == TRACK_SAR_CLOCKS - 5'h01) begin
                            state_reg <= CONVERT;
                            count_reg <= '0;
                        end else begin
                            count_reg <= count_reg + 5'h01;
                        end
                    end
                end
                CONVERT: begin
                    if (finish) begin
                        state_reg <= IDLE;
                        count_reg <= '0;
                    end else if (sarTick) begin
                        count_reg <= count_reg + 5'h01;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // busy, done flag and result
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            convBusy <= 1'b0;
        end else begin
            convBusy <= active && (state_reg != IDLE ? !finish : startEvent);
        end
    end

    // set wins over clear; hardware never clears
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            convDoneFlag <= 1'b0;
            convIrq      <= 1'b0;
        end else begin
            if (active && finish) begin
                convDoneFlag <= 1'b1;
            end else if (doneFlagClear) begin
                convDoneFlag <= 1'b0;
            end
            convIrq <= doneIrqEnable & (convDoneFlag | (active & finish));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resultHigh <= 8'h00;
            resultLow  <= 8'h00;
        end else if (active && finish) begin
            // core already delivers twos complement for differential pairs
            if (leftJustify) begin
                resultHigh <= sarData[9:2];
                resultLow  <= {sarData[1:0], 6'h00};
            end else begin
                resultHigh <= {{6{diffSel & sarData[9]}}, sarData[9:8]};
                resultLow  <= sarData[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // multiplexer configuration and analog controls
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pairConfig <= PAIR_CFG_RESET;
        end else if (pairConfigWrite) begin
            pairConfig <= muxPairConfig;
        end
    end

    assign diffSel = !muxChannelSelect[3] && pairConfig[muxChannelSelect[2:1]];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            muxChannel      <= '0;
            muxDifferential <= 1'b0;
            muxTempSensor   <= 1'b0;
            analogPowerUp   <= 1'b0;
            trackActive     <= 1'b0;
            sarConvert      <= 1'b0;
        end else begin
            // channels 8 to 15 all select the sensor
            muxChannel      <= muxChannelSelect[3] ? TEMP_SENSOR_CHAN : muxChannelSelect;
            muxDifferential <= diffSel;
            muxTempSensor   <= muxChannelSelect[3];
            analogPowerUp   <= convEnable;
            sarConvert      <= active && state_reg == CONVERT;
            if (!active || stbySync2_reg) begin
                trackActive <= 1'b0;
            end else if (!trackMode) begin
                trackActive <= state_reg != CONVERT && !idleStart;
            end else if (startMode == START_EXTPIN) begin
                trackActive <= !pinSync2_reg && state_reg != CONVERT;
            end else begin
                trackActive <= state_reg == TRACK;
            end
        end
    end
endmodule
`default_nettype wire

//--- inc/sarcc_pkg.sv
// package for the converter control block: field codes and timing counts
// assumes nothing beyond a single system clock
package sarcc_pkg;
    // ------------------------------------------------------------
    // start mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] START_SOFTWARE = 2'h0;
    localparam logic [1:0] START_TIMER3   = 2'h1;
    localparam logic [1:0] START_EXTPIN   = 2'h2;
    localparam logic [1:0] START_TIMER2   = 2'h3;
    // ------------------------------------------------------------
    // widths, reset values and counts
    // ------------------------------------------------------------
    localparam int          RESULT_WIDTH     = 10;
    localparam int          CHAN_WIDTH       = 4;
    localparam int          PAIR_COUNT       = 4;
    localparam logic [3:0]  PAIR_CFG_RESET   = 4'h0;
    localparam logic [3:0]  TEMP_SENSOR_CHAN = 4'h8;
    localparam logic [2:0]  DIVIDER_RESET    = 3'h3;
    localparam logic [4:0]  TRACK_SAR_CLOCKS = 5'h03;
    localparam logic [4:0]  CONV_SAR_CLOCKS  = 5'h10;
    localparam int          DIV_CNT_WIDTH    = 4;
endpackage

//--- verif/sar_adc_conversion_control_test.sv
// bench for the converter control block
// assumes the core model drives sarData
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_test;
    import sarcc_pkg::*;
    logic clk = 0, sys_rst = 1, convEnable = 0, refBiasEnable = 0, trackMode = 0;
    logic startModeHi = 0, startModeLo = 0, leftJustify = 0, pairConfigWrite = 0;
    logic busyWrite = 0, timer3Overflow = 0, timer2Overflow = 0, extConvStart = 0;
    logic chipStandby = 0, doneFlagClear = 0, doneIrqEnable = 0;
    logic convBusy, convDoneFlag, convIrq, analogPowerUp, trackActive, sarConvert;
    logic muxDifferential, muxTempSensor;
    logic [2:0] convClockDivider = 3'h0;
    logic [3:0] muxChannelSelect = 4'h0, muxPairConfig = 4'h0, muxChannel, pairConfig;
    logic [9:0] sarData, code = 10'h000;
    logic [7:0] resultHigh, resultLow;
    int fail_count = 0, comparisons = 0, n, i, m, s, d;
    always #20 clk = ~clk;
    sarcc_top u_sarcc_top (.clk, .sys_rst, .convEnable, .refBiasEnable, .trackMode,
        .startModeHi, .startModeLo, .leftJustify, .convClockDivider, .muxChannelSelect,
        .muxPairConfig, .pairConfigWrite, .busyWrite, .timer3Overflow, .timer2Overflow,
        .extConvStart, .chipStandby, .doneFlagClear, .doneIrqEnable, .sarData, .convBusy,
        .convDoneFlag, .convIrq, .resultHigh, .resultLow, .analogPowerUp, .trackActive,
        .sarConvert, .muxChannel, .muxDifferential, .muxTempSensor, .pairConfig);
    sarcc_core_model u_sarcc_core_model (.sarConvert, .code, .sarData);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic fire(input int src);
        @(negedge clk);
        case (src)
            0: busyWrite = 1;
            1: timer3Overflow = 1;
            2: extConvStart = 1;
            default: timer2Overflow = 1;
        endcase
        @(negedge clk);
        {busyWrite, timer3Overflow, timer2Overflow} = 3'h0;
        // pin held a while, it passes a two-flop synchroniser
        if (src == 2) begin
            repeat (4) @(negedge clk);
            extConvStart = 0;
        end
    endtask
    task automatic tail;
        for (i = 0; i < 8 && convBusy !== 1'b1; i++) @(negedge clk);
        for (n = 0; convBusy === 1'b1 && n < 600; n++) @(negedge clk);
    endtask
    task automatic run(input int src);
        fire(src);
        tail();
    endtask
    task automatic clear_flag;
        @(negedge clk);
        doneFlagClear = 1;
        @(negedge clk);
        doneFlagClear = 0;
    endtask
    task automatic set_pairs(input logic [3:0] v);
        @(negedge clk);
        {muxPairConfig, pairConfigWrite} = {v, 1'b1};
        @(negedge clk);
        pairConfigWrite = 0;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        #800000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 0;
        chk("pairs", pairConfig, 0);
        {convEnable, doneIrqEnable, code} = {2'h3, 10'h2A5};
        run(0);
        chk("no bias", n, 0);
        refBiasEnable = 1;
        run(0);
        chk("busy len", n, 17);
        chk("flag", convDoneFlag, 1);
        chk("high", resultHigh, 10'h002);
        chk("low", resultLow, 10'h0A5);
        repeat (4) @(negedge clk);
        chk("irq", convIrq, 1);
        chk("sticky", convDoneFlag, 1);
        clear_flag();
        fire(0);
        repeat (3) fire(0);
        tail();
        chk("restart", n + 6, 17);
        leftJustify = 1;
        clear_flag();
        fire(0);
        for (n = 0; convDoneFlag !== 1'b1 && n < 600; n++) @(negedge clk);
        chk("poll", n, 17);
        chk("left high", resultHigh, 10'h0A9);
        chk("left low", resultLow, 10'h040);
        {leftJustify, code} = {1'b0, 10'h3F0};
        set_pairs(4'h1);
        run(0);
        chk("diff", muxDifferential, 1);
        chk("sign", resultHigh, 10'h0FF);
        set_pairs(4'h0);
        muxChannelSelect = 4'h9;
        repeat (2) @(negedge clk);
        chk("temp", muxChannel, 10'h008);
        muxChannelSelect = 4'h0;
        for (d = 1; d < 5; d++) begin
            convClockDivider = d[2:0];
            run(0);
            chk("div", n >= (15 << d) + 1 && n <= (17 << d) + 1, 1);
        end
        {convClockDivider, trackMode} = 4'h1;
        run(0);
        chk("timed", n, 20);
        trackMode = 0;
        for (m = 0; m < 4; m++) begin
            {startModeHi, startModeLo} = m[1:0];
            for (s = 0; s < 4; s++) if (s != m) fire(s);
            repeat (6) @(negedge clk);
            chk("foreign", convBusy, 0);
            run(m);
            chk("own", n > 0, 1);
        end
        {trackMode, startModeHi, startModeLo} = 3'h6;
        repeat (6) @(negedge clk);
        chk("pin low", trackActive, 1);
        extConvStart = 1;
        repeat (6) @(negedge clk);
        chk("pin high", trackActive, 0);
        tail();
        {extConvStart, trackMode, startModeHi, startModeLo} = 4'h0;
        repeat (6) @(negedge clk);
        chk("track idle", trackActive, 1);
        chipStandby = 1;
        repeat (6) @(negedge clk);
        chk("standby", trackActive, 0);
        chipStandby = 0;
        convClockDivider = 3'h3;
        clear_flag();
        fire(0);
        repeat (4) @(negedge clk);
        chk("running", {convBusy, sarConvert, analogPowerUp}, 10'h007);
        convEnable = 0;
        repeat (4) @(negedge clk);
        chk("abort", {convBusy, convDoneFlag, analogPowerUp}, 0);
        run(0);
        chk("off", n, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- verif/sarcc_core_model.sv
// stand-in for the analog converter core behind sarData
// assumes the bench picks the code, in twos complement for differential pairs
`timescale 1ns/1ps
`default_nettype none
module sarcc_core_model (
    input  wire logic                                 sarConvert,
    input  wire logic [sarcc_pkg::RESULT_WIDTH-1:0]   code,
    output logic      [sarcc_pkg::RESULT_WIDTH-1:0]   sarData
);
    import sarcc_pkg::*;
    // idle core shows the inverse, so a stale sample never matches
    assign sarData = sarConvert ? code : ~code;
endmodule
`default_nettype wire

//--- verif/sarcc_top_assertions.sv
// port assertions for the converter control block
// assumes one clock domain; bound into every sarcc_top
`timescale 1ns/1ps
`default_nettype none
module sarcc_top_assertions (
    input wire logic                                 clk,
    input wire logic                                 sys_rst,
    input wire logic                                 convEnable,
    input wire logic                                 refBiasEnable,
    input wire logic                                 trackMode,
    input wire logic                                 startModeHi,
    input wire logic                                 startModeLo,
    input wire logic                                 leftJustify,
    input wire logic [2:0]                           convClockDivider,
    input wire logic [sarcc_pkg::CHAN_WIDTH-1:0]     muxChannelSelect,
    input wire logic                                 busyWrite,
    input wire logic                                 chipStandby,
    input wire logic                                 doneFlagClear,
    input wire logic                                 doneIrqEnable,
    input wire logic [sarcc_pkg::RESULT_WIDTH-1:0]   sarData,
    input wire logic                                 convBusy,
    input wire logic                                 convDoneFlag,
    input wire logic                                 convIrq,
    input wire logic [7:0]                           resultHigh,
    input wire logic [sarcc_pkg::CHAN_WIDTH-1:0]     muxChannel,
    input wire logic                                 muxDifferential,
    input wire logic                                 muxTempSensor,
    input wire logic                                 trackActive
);
    import sarcc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_start;
        busyWrite && {startModeHi, startModeLo} == START_SOFTWARE && convEnable
            && refBiasEnable && !convBusy |=> convBusy;
    endproperty
    property p_off;
        !convEnable [*3] |-> !convBusy;
    endproperty
    property p_done;
        $fell(convBusy) && $past(convEnable) && convEnable |-> convDoneFlag;
    endproperty
    property p_sticky;
        convDoneFlag && !doneFlagClear |=> convDoneFlag;
    endproperty
    property p_irq;
        convIrq == ($past(doneIrqEnable) && (convDoneFlag || $past(convDoneFlag)));
    endproperty
    // abort by disable is not kept out, though it ends a conversion early
    property p_dur;
        $rose(convBusy) && convClockDivider == 3'h0 && !trackMode |->
            convBusy [*8] ##1 convBusy [*8] ##1 convBusy ##1 !convBusy;
    endproperty
    property p_result;
        $fell(convBusy) && convDoneFlag && !muxDifferential |-> resultHigh ==
            ($past(leftJustify) ? $past(sarData[9:2]) : {6'h00, $past(sarData[9:8])});
    endproperty
    property p_temp;
        $past(muxChannelSelect[3]) |-> muxTempSensor && muxChannel == TEMP_SENSOR_CHAN;
    endproperty
    property p_standby;
        chipStandby [*5] |-> !trackActive;
    endproperty
    property p_busytrack;
        !trackMode && convBusy |-> !trackActive;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    a_off: assert property (p_off) else $error("busy while disabled");
    a_done: assert property (p_done) else $error("flag not set");
    a_sticky: assert property (p_sticky) else $error("flag cleared");
    a_irq: assert property (p_irq) else $error("irq mismatch");
    a_dur: assert property (p_dur) else $error("busy length");
    a_result: assert property (p_result) else $error("result layout");
    a_temp: assert property (p_temp) else $error("temp channel");
    a_standby: assert property (p_standby) else $error("track in standby");
    a_busytrack: assert property (p_busytrack) else $error("track busy");
    c_done: cover property ($fell(convBusy));
    c_irq: cover property (convIrq);
    c_track: cover property (trackActive && convBusy);
endmodule
bind sarcc_top sarcc_top_assertions u_sarcc_top_assertions (.clk, .sys_rst, .convEnable,
    .refBiasEnable, .trackMode, .startModeHi, .startModeLo, .leftJustify, .convClockDivider,
    .muxChannelSelect, .busyWrite, .chipStandby, .doneFlagClear, .doneIrqEnable, .sarData,
    .convBusy, .convDoneFlag, .convIrq, .resultHigh, .muxChannel, .muxDifferential,
    .muxTempSensor, .trackActive);
`default_nettype wire
